/* rtl/rail_shutdown_consts.svh */
`ifndef RAIL_SHUTDOWN_CONSTS_SVH
`define RAIL_SHUTDOWN_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_RAIL1_OFF_DLY     8'h57
`define IDX_RAIL2_FB_DIV      8'h58
`define IDX_RAIL2_LIGHT_LOAD  8'h5B
`define IDX_RAIL2_SW_FREQ     8'h5C
`define IDX_RAIL2_CFG_DISCH   8'h5D
`define IDX_PIN_CTRL          8'h80
`define IDX_RAIL1_STATUS      8'h81

// reset values
`define RST_RAIL1_OFF_DLY     8'h00
`define RST_RAIL2_FB_DIV      8'h00
`define RST_RAIL2_LIGHT_LOAD  3'h0
`define RST_RAIL2_SW_FREQ     8'h00
`define RST_RAIL2_CFG_HI      4'h8
`define RST_RAIL2_DISCH       2'h0
`define RST_PIN_CTRL          3'h0

// field positions
`define F_DVS_SRC             7:6
`define F_OFF_DLY             5:0
`define F_FB_DIV              7:6
`define F_FCCM                2
`define F_LIGHT_LOAD_KEEP     2:0
`define F_FREQ_SEL            7:6
`define F_CFG_HI              7:4
`define F_DISCH               1:0
`define F_PIN_MODE            1:0
`define F_DVS_GATE            2

// encodings
`define PIN_MODE_DVS          2'h3
`define DVS_SRC_PIN_A         2'h0
`define DVS_SRC_PIN_B         2'h1
`define DVS_SRC_ONE           2'h3
`define DISCH_OFF             2'h0
`define DISCH_ON              2'h1

// timing
`define CLK_PERIOD_NS         8
`define OFF_DLY_STEP_NS       1000000
`define MS_TICK_CYCLES        (`OFF_DLY_STEP_NS / `CLK_PERIOD_NS)

`endif

/* rtl/rail_cfg_pkg.sv */
`default_nettype none
package rail_cfg_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [5:0] off_delay_t;
    typedef enum logic [1:0] {SD_OFF, SD_ON, SD_COUNT} shutdown_state_t;
endpackage
`default_nettype wire

/* rtl/ms_tick_gen.sv */
`include "rail_shutdown_consts.svh"
`default_nettype none
module ms_tick_gen #(
    parameter int unsigned PERIOD = `MS_TICK_CYCLES
) (
    input  wire logic ref_clk,  // core clock
    input  wire logic rst_n,    // async reset, active low
    input  wire logic clear,    // restart the period
    output logic      tick      // one-cycle pulse per period
);
    localparam int unsigned CW = (PERIOD > 2) ? $clog2(PERIOD) : 1;
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] count;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            count <= '0;
        else if (clear || count == LAST)
            count <= '0;
        else
            count <= count + CW'(1);
    end

    assign tick = (count == LAST) && !clear;
endmodule
`default_nettype wire

/* rtl/rail_shutdown_dvs_pin_cfg.sv */
// Functional notes
// - the dvs source field drives the voltage-set select from a pin only while the pin function mode is 3.
// - in mode 3 the high select is held at 0 and the low select is the chosen pin (a, b, none, one) gated by the gate bit.
// - in any mode other than 3 the pins are ignored for voltage-set selection.
// - after the rail enable pin or regulator valid input falls, the rail enable drops after the delay field in ms, or after 1 ms when the field is 0.
// - with discharge select 0 the output pulldown stays inactive when the rail is off.
// - with discharge select 1 the output pulldown is active when the rail is off.
`include "rail_shutdown_consts.svh"
`default_nettype none
module rail_shutdown_dvs_pin_cfg #(
    parameter int unsigned TICK_CYCLES = `MS_TICK_CYCLES,
    parameter logic        TRIM_BIT    = 1'b0   // arbitrary factory trim value
) (
    input  wire logic        ref_clk,                  // 125 MHz core clock
    input  wire logic        rst_n,                    // async reset, active low
    input  wire logic [9:0]  address,                  // avalon byte address
    input  wire logic        read,                     // avalon read
    input  wire logic        write,                    // avalon write
    input  wire logic [31:0] writedata,                // avalon write data
    input  wire logic [3:0]  byteenable,               // avalon byte enables
    output logic      [31:0] readdata,                 // avalon read data
    output logic             waitrequest,              // avalon wait
    input  wire logic        enable_pin_a,             // external pin a
    input  wire logic        enable_pin_b,             // external pin b
    input  wire logic        rail_enable_pin,          // rail enable pin
    input  wire logic        regulator_valid_input,    // regulator valid input
    output logic             rail1_on_control,         // rail 1 internal enable
    output logic             output_discharge_active,  // rail output pulldown
    output logic             voltage_set_select_low,   // voltage set select bit 0
    output logic             voltage_set_select_high,  // voltage set select bit 1
    output logic             dvs_pins_in_control,      // pins steer voltage set
    output logic      [1:0]  rail2_feedback_divider_field, // rail 2 feedback divider
    output logic             rail2_forced_continuous,  // rail 2 forced continuous
    output logic      [1:0]  rail2_frequency_select    // rail 2 frequency select
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end
        else
        begin
            pin_meta <= {regulator_valid_input, rail_enable_pin, enable_pin_b, enable_pin_a};
            pin_sync <= pin_meta;
        end
    end
    logic enables_ok;
    assign enables_ok = pin_sync[2] & pin_sync[3];

    // ------------------------------------------------------------
    // avalon slave
    // ------------------------------------------------------------
    rail_cfg_pkg::reg_byte_t rail1_off_delay_and_dvs_pin;
    rail_cfg_pkg::reg_byte_t rail2_feedback_divider;
    logic [2:0]              rail2_light_load_mode;
    rail_cfg_pkg::reg_byte_t rail2_switching_frequency;
    logic [3:0]              rail2_cfg_hi;
    logic [1:0]              rail2_discharge;
    logic [2:0]              pin_ctrl;
    rail_cfg_pkg::reg_byte_t rd_byte;
    rail_cfg_pkg::reg_byte_t status_byte;
    rail_cfg_pkg::shutdown_state_t sd_state;
    logic [7:0] word_idx;
    logic       wr_accept;
    assign word_idx  = address[9:2];
    assign wr_accept = !waitrequest && write && byteenable[0];
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            waitrequest <= 1'b1;
        else if (waitrequest && (read || write))
            waitrequest <= 1'b0;
        else
            waitrequest <= 1'b1;
    end
    always_comb
    begin
        case (word_idx)
            `IDX_RAIL1_OFF_DLY:    rd_byte = rail1_off_delay_and_dvs_pin;
            `IDX_RAIL2_FB_DIV:     rd_byte = rail2_feedback_divider;
            `IDX_RAIL2_LIGHT_LOAD: rd_byte = {5'h00, rail2_light_load_mode};
            `IDX_RAIL2_SW_FREQ:    rd_byte = rail2_switching_frequency;
            `IDX_RAIL2_CFG_DISCH:  rd_byte = {rail2_cfg_hi, TRIM_BIT, 1'b0, rail2_discharge};
            `IDX_PIN_CTRL:         rd_byte = {5'h00, pin_ctrl};
            `IDX_RAIL1_STATUS:     rd_byte = status_byte;
            default:               rd_byte = 8'h00;
        endcase
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            readdata <= 32'h0000_0000;
        else if (waitrequest && read)
            readdata <= {24'h00_0000, rd_byte};
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rail1_off_delay_and_dvs_pin <= `RST_RAIL1_OFF_DLY;
            rail2_feedback_divider      <= `RST_RAIL2_FB_DIV;
            rail2_light_load_mode       <= `RST_RAIL2_LIGHT_LOAD;
            rail2_switching_frequency   <= `RST_RAIL2_SW_FREQ;
            rail2_cfg_hi                <= `RST_RAIL2_CFG_HI;
            rail2_discharge             <= `RST_RAIL2_DISCH;
            pin_ctrl                    <= `RST_PIN_CTRL;
        end
        else if (wr_accept)
        begin
            case (word_idx)
                `IDX_RAIL1_OFF_DLY:    rail1_off_delay_and_dvs_pin <= writedata[7:0];
                `IDX_RAIL2_FB_DIV:     rail2_feedback_divider      <= writedata[7:0];
                `IDX_RAIL2_LIGHT_LOAD: rail2_light_load_mode       <= writedata[`F_LIGHT_LOAD_KEEP];
                `IDX_RAIL2_SW_FREQ:    rail2_switching_frequency   <= writedata[7:0];
                `IDX_RAIL2_CFG_DISCH:
                begin
                    rail2_cfg_hi    <= writedata[`F_CFG_HI];
                    rail2_discharge <= writedata[`F_DISCH];
                end
                `IDX_PIN_CTRL:         pin_ctrl <= writedata[2:0];
                default:               ;
            endcase
        end
    end
    assign rail2_feedback_divider_field = rail2_feedback_divider[`F_FB_DIV];
    assign rail2_forced_continuous      = rail2_light_load_mode[`F_FCCM];
    assign rail2_frequency_select       = rail2_switching_frequency[`F_FREQ_SEL];

    // ------------------------------------------------------------
    // voltage-set pin selection
    // ------------------------------------------------------------
    logic dvs_mode;
    logic dvs_pin_level;
    assign dvs_mode = (pin_ctrl[`F_PIN_MODE] == `PIN_MODE_DVS);
    always_comb
    begin
        case (rail1_off_delay_and_dvs_pin[`F_DVS_SRC])
            `DVS_SRC_PIN_A: dvs_pin_level = pin_sync[0];
            `DVS_SRC_PIN_B: dvs_pin_level = pin_sync[1];
            `DVS_SRC_ONE:   dvs_pin_level = 1'b1;
            default:        dvs_pin_level = 1'b0;
        endcase
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            voltage_set_select_low  <= 1'b0;
            voltage_set_select_high <= 1'b0;
            dvs_pins_in_control     <= 1'b0;
        end
        else
        begin
            voltage_set_select_low  <= dvs_mode & dvs_pin_level & pin_ctrl[`F_DVS_GATE];
            voltage_set_select_high <= 1'b0;
            dvs_pins_in_control     <= dvs_mode;
        end
    end

    // ------------------------------------------------------------
    // shutdown delay
    // ------------------------------------------------------------
    logic                    ms_tick;
    logic                    sd_start;
    rail_cfg_pkg::off_delay_t sd_remaining;
    assign sd_start = (sd_state == rail_cfg_pkg::SD_ON) && !enables_ok;
    ms_tick_gen #(.PERIOD(TICK_CYCLES)) u_tick (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clear   (sd_start),
        .tick    (ms_tick)
    );
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sd_state         <= rail_cfg_pkg::SD_OFF;
            sd_remaining     <= 6'h00;
            rail1_on_control <= 1'b0;
        end
        else
        begin
            case (sd_state)
                rail_cfg_pkg::SD_OFF:
                    if (enables_ok)
                    begin
                        sd_state         <= rail_cfg_pkg::SD_ON;
                        rail1_on_control <= 1'b1;
                    end
                rail_cfg_pkg::SD_ON:
                    if (!enables_ok)
                    begin
                        sd_state     <= rail_cfg_pkg::SD_COUNT;
                        sd_remaining <= rail1_off_delay_and_dvs_pin[`F_OFF_DLY];
                    end
                rail_cfg_pkg::SD_COUNT:
                    if (enables_ok)
                        sd_state <= rail_cfg_pkg::SD_ON;
                    else if (ms_tick)
                    begin
                        if (sd_remaining <= 6'h01)
                        begin
                            sd_state         <= rail_cfg_pkg::SD_OFF;
                            rail1_on_control <= 1'b0;
                        end
                        else
                            sd_remaining <= sd_remaining - 6'h01;
                    end
                default:
                    sd_state <= rail_cfg_pkg::SD_OFF;
            endcase
        end
    end
    // values 2 and 3 of the select leave the pulldown off
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            output_discharge_active <= 1'b0;
        else
            output_discharge_active <= (sd_state == rail_cfg_pkg::SD_OFF)
                                       && (rail2_discharge == `DISCH_ON);
    end
    assign status_byte = {4'h0, dvs_pins_in_control, output_discharge_active,
                          sd_state == rail_cfg_pkg::SD_COUNT, rail1_on_control};

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    int unsigned sd_cycles;
    int unsigned sd_delay_seen;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sd_cycles     <= 0;
            sd_delay_seen <= 0;
        end
        else if (sd_start)
        begin
            sd_cycles     <= 1;
            sd_delay_seen <= int'(rail1_off_delay_and_dvs_pin[`F_OFF_DLY]);
        end
        else if (sd_state == rail_cfg_pkg::SD_COUNT)
            sd_cycles <= sd_cycles + 1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_dvs_off_mode;
        (pin_ctrl[`F_PIN_MODE] != `PIN_MODE_DVS) |=> !voltage_set_select_low && !dvs_pins_in_control;
    endproperty
    a_dvs_off_mode: assert property (p_dvs_off_mode) else $error("pins steer select outside mode 3");
    property p_dvs_const_one;
        dvs_mode && pin_ctrl[`F_DVS_GATE] && rail1_off_delay_and_dvs_pin[`F_DVS_SRC] == `DVS_SRC_ONE
            |=> voltage_set_select_low;
    endproperty
    a_dvs_const_one: assert property (p_dvs_const_one) else $error("constant-one source not honoured");
    property p_dvs_pin_a;
        dvs_mode && rail1_off_delay_and_dvs_pin[`F_DVS_SRC] == `DVS_SRC_PIN_A
            |=> voltage_set_select_low == ($past(pin_sync[0]) && $past(pin_ctrl[`F_DVS_GATE]));
    endproperty
    a_dvs_pin_a: assert property (p_dvs_pin_a) else $error("low select does not follow pin a");
    property p_dvs_high_zero;
        ##1 !voltage_set_select_high;
    endproperty
    a_dvs_high_zero: assert property (p_dvs_high_zero) else $error("high select not zero");
    property p_off_delay_time;
        (sd_state == rail_cfg_pkg::SD_COUNT && !enables_ok && ms_tick && sd_remaining <= 6'h01)
            |-> sd_cycles == TICK_CYCLES * ((sd_delay_seen == 0) ? 1 : sd_delay_seen);
    endproperty
    a_off_delay_time: assert property (p_off_delay_time) else $error("shutdown delay length wrong");
    property p_off_on_tick;
        $fell(rail1_on_control) |-> $past(ms_tick) && !$past(enables_ok);
    endproperty
    a_off_on_tick: assert property (p_off_on_tick) else $error("rail dropped off a tick");
    property p_disch_idle;
        rail2_discharge == `DISCH_OFF |=> !output_discharge_active;
    endproperty
    a_disch_idle: assert property (p_disch_idle) else $error("pulldown active with select 0");
    property p_disch_on;
        !rail1_on_control && sd_state == rail_cfg_pkg::SD_OFF && rail2_discharge == `DISCH_ON
            |=> output_discharge_active;
    endproperty
    a_disch_on: assert property (p_disch_on) else $error("pulldown idle with select 1");
    c_rail_off:    cover property ($fell(rail1_on_control));
    c_cancel:      cover property (sd_state == rail_cfg_pkg::SD_COUNT && enables_ok);
    c_dvs_low:     cover property (voltage_set_select_low);
    c_discharge:   cover property (output_discharge_active);
endmodule
`default_nettype wire

/* tb/tb_rail_shutdown_dvs_pin_cfg.sv */
`default_nettype none
module tb_rail_shutdown_dvs_pin_cfg;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 8;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [9:0]  address = 10'h000;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0]  byteenable = 4'hF;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        pin_a = 1'b0;
    logic        pin_b = 1'b0;
    logic        en_pin = 1'b0;
    logic        valid_in = 1'b0;
    logic        rail_on;
    logic        disch;
    logic        vsel_lo;
    logic        vsel_hi;
    logic        in_ctrl;
    logic [1:0]  fb_div;
    logic        fccm;
    logic [1:0]  fsel;
    int          fail_count = 0;
    int          tests_run = 0;

    always #4 ref_clk = ~ref_clk;

    rail_shutdown_dvs_pin_cfg #(.TICK_CYCLES(TICK), .TRIM_BIT(1'b0)) u_rail_shutdown_dvs_pin_cfg (
        .ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .enable_pin_a(pin_a), .enable_pin_b(pin_b), .rail_enable_pin(en_pin),
        .regulator_valid_input(valid_in), .rail1_on_control(rail_on), .output_discharge_active(disch),
        .voltage_set_select_low(vsel_lo), .voltage_set_select_high(vsel_hi), .dvs_pins_in_control(in_ctrl),
        .rail2_feedback_divider_field(fb_div), .rail2_forced_continuous(fccm), .rail2_frequency_select(fsel)
    );

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // request held until waitrequest is sampled low
    task automatic bus(input logic is_wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge ref_clk);
        address <= {idx, 2'b00};
        read <= ~is_wr;
        write <= is_wr;
        writedata <= {24'h000000, wd};
        // only the watchdog ends a wait that never completes
        do
        begin
            @(posedge ref_clk);
        end
        while (waitrequest !== 1'b0);
        rd = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        bus(1'b1, idx, wd, d);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        bus(1'b0, idx, 8'h00, d);
        check({24'h000000, d}, {24'h000000, exp});
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_regs();
        rd_chk(8'h57, 8'h00);
        rd_chk(8'h58, 8'h00);
        rd_chk(8'h5B, 8'h00);
        rd_chk(8'h5C, 8'h00);
        rd_chk(8'h5D, 8'h80);
        wr(8'h58, 8'hFF);
        wr(8'h5B, 8'hFF);
        wr(8'h5C, 8'hFF);
        wr(8'h5D, 8'hFF);
        rd_chk(8'h58, 8'hFF);
        rd_chk(8'h5B, 8'h07);
        rd_chk(8'h5C, 8'hFF);
        rd_chk(8'h5D, 8'hF3);
        check({29'h0, fb_div, fccm}, 32'h0000_0007);
        check({30'h0, fsel}, 32'h0000_0003);
        byteenable <= 4'hE;
        wr(8'h58, 8'h00);
        byteenable <= 4'hF;
        rd_chk(8'h58, 8'hFF);
        wr(8'h3F, 8'hA5);
        rd_chk(8'h3F, 8'h00);
        $display("test registers done");
    endtask

    task automatic test_dvs();
        logic exp;
        for (int m = 0; m < 4; m++)
            for (int s = 0; s < 4; s++)
                for (int p = 0; p < 2; p++)
                begin
                    pin_a <= p[0];
                    pin_b <= ~p[0];
                    wr(8'h57, {s[1:0], 6'h00});
                    wr(8'h80, {5'h00, 1'b1, m[1:0]});
                    cycles(5);
                    exp = (m == 3) && (s == 0 ? p[0] : s == 1 ? ~p[0] : s == 3);
                    check({31'h0, vsel_lo}, {31'h0, exp});
                    check({30'h0, vsel_hi, in_ctrl}, {30'h0, 1'b0, m == 3});
                end
        wr(8'h57, 8'hC0);
        wr(8'h80, 8'h03);
        cycles(5);
        check({31'h0, vsel_lo}, 32'h0000_0000);
        wr(8'h80, 8'h00);
        $display("test dvs done");
    endtask

    task automatic test_shutdown(input logic [5:0] dly, input logic [1:0] sel, input logic use_valid);
        int n;
        int t;
        t = TICK * ((dly == 0) ? 1 : int'(dly));
        wr(8'h57, {2'b00, dly});
        wr(8'h5D, {6'h20, sel});
        @(posedge ref_clk);
        en_pin <= 1'b1;
        valid_in <= 1'b1;
        cycles(6);
        check({31'h0, rail_on}, 32'h0000_0001);
        check({31'h0, disch}, 32'h0000_0000);
        rd_chk(8'h81, 8'h01);
        if (use_valid)
            valid_in <= 1'b0;
        else
            en_pin <= 1'b0;
        n = 0;
        while (rail_on === 1'b1 && n < 1000)
        begin
            @(posedge ref_clk);
            n++;
        end
        check({31'h0, n >= t + 1 && n <= t + 6}, 32'h0000_0001);
        cycles(3);
        check({31'h0, disch}, {31'h0, sel == 2'h1});
        $display("test shutdown delay %0d select %0d done", dly, sel);
    endtask

    task automatic test_cancel();
        wr(8'h57, 8'h05);
        @(posedge ref_clk);
        en_pin <= 1'b1;
        valid_in <= 1'b1;
        cycles(6);
        en_pin <= 1'b0;
        cycles(10);
        en_pin <= 1'b1;
        cycles(60);
        check({31'h0, rail_on}, 32'h0000_0001);
        $display("test cancel done");
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        cycles(10);
        rst_n <= 1'b1;
        test_regs();
        test_dvs();
        test_shutdown(6'd0, 2'h1, 1'b0);
        test_shutdown(6'd3, 2'h0, 1'b1);
        test_shutdown(6'd63, 2'h1, 1'b1);
        test_shutdown(6'd2, 2'h2, 1'b0);
        test_cancel();
        tally_and_finish();
    end

    initial
    begin
        cycles(20000);
        fail_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
